// ### design/brs_pkg.sv
// Constants for the boot/normal memory-map switch and its status register.
// Assumes an 8-bit MCU with separate code and data (XDATA) spaces of 64K each.
package brs_pkg;

   // -----------------------------------------------------------------
   // Register addresses in data space
   // -----------------------------------------------------------------
   localparam logic [15:0] ROM_SHADOW_CONFIG_ADDR = 16'hFF90;
   localparam logic [15:0] USB_CONTROL_REG_ADDR   = 16'hFFFC;

   // -----------------------------------------------------------------
   // Field positions and fixed values
   // -----------------------------------------------------------------
   localparam int          SHADOW_SWITCH_POS  = 0;
   localparam int          RSVD_LSB           = 1;
   localparam int          RSVD_MSB           = 4;
   localparam int          CODE_SIZE_LSB      = 5;
   localparam int          CODE_SIZE_MSB      = 6;
   localparam int          CODE_IS_RAM_POS    = 7;
   localparam int          BUS_ATTACH_POS     = 7;
   localparam logic [3:0]  RSVD_VALUE         = 4'h0;
   localparam logic [1:0]  CODE_SIZE_4K       = 2'h0;
   localparam logic [1:0]  CODE_SIZE_8K       = 2'h1;
   localparam logic [1:0]  CODE_SIZE_16K      = 2'h2;
   localparam logic [1:0]  CODE_SIZE_32K      = 2'h3;
   localparam logic        CODE_IS_RAM_VALUE  = 1'b1;
   localparam logic        SHADOW_RESET       = 1'b0;
   localparam logic        BUS_ATTACH_RESET   = 1'b0;

   // -----------------------------------------------------------------
   // Memory map
   // -----------------------------------------------------------------
   localparam int          ROM_AW             = 14;
   localparam int          RAM_AW             = 14;
   localparam logic [15:0] ROM_LOW_BASE       = 16'h0000;
   localparam logic [15:0] ROM_LOW_LAST       = 16'h27FF;
   localparam logic [15:0] ROM_HIGH_BASE      = 16'h8000;
   localparam logic [15:0] ROM_HIGH_LAST      = 16'hA7FF;
   localparam logic [15:0] RAM_BASE           = 16'h0000;
   localparam logic [15:0] RAM_LAST           = 16'h3FFF;

   // Cycles from a taken read to its valid strobe
   localparam int          READ_LATENCY       = 2;

   // -----------------------------------------------------------------
   // Source of an access
   // -----------------------------------------------------------------
   typedef enum logic [4:0]
   {
      SRC_IDLE = 5'h01,
      SRC_ROM  = 5'h02,
      SRC_RAM  = 5'h04,
      SRC_REG  = 5'h08,
      SRC_ZERO = 5'h10
   } brs_src_e;

endpackage

// ### design/brs_code_ram.sv
// Single-port program RAM with registered read data.
// Assumes one access per cycle; read data appear the cycle after en.
`timescale 1ns/100ps
module brs_code_ram #(
   parameter int AW = 14,
   parameter int DW = 8
) (
   // Clock
   input  wire logic          clk,
   // Access port
   input  wire logic          en,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   output      logic [DW-1:0] rdata
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk)
   begin
      if (en)
      begin
         if (we)
         begin
            mem[addr] <= wdata;
         end
         rdata <= mem[addr];
      end
   end

endmodule

// ### design/brs_shadow_map.sv
// Boot/normal memory-map switch with its shadow configuration register.
// Assumes the MCU, boot ROM and watchdog share CLK; the ROM answers one
// cycle after ROM_RD. Code fetch wins when both spaces are requested.
//
// Notes on behaviour
// (R1) Shadow clear: code fetches come from boot ROM at 0000h and 8000h.
// (R2) Shadow clear: 16K RAM sits in data space, readable and writable.
// (R3) Shadow set: ROM only at 8000h, RAM is code space from 0000h.
// (R4) Shadow set: every write to the program RAM is blocked.
// (R5) Shadow bit only set by MCU; cleared only by power-up or watchdog reset.
// (R6) Reserved bits 4..1 of the shadow register always read zero.
// (R7) Code-size field bits 6..5 fixed at 10b, read-only, reset-proof.
// (R8) Code-size codes: 00=4K, 01=8K, 10=16K, 11=32K.
// (R9) Bit 7 fixed at 1, read-only: code space is RAM.
// (R10) Reset clears shadow bit and bus attach bit: boot mode, detached.
// (R11) First fetch after reset is at 0000h, inside boot ROM.
// (R12) Boot firmware checks serial memory signature, loads image via data space.
// (R13) Setting shadow bit switches map; execution continues from RAM at 0000h.
// (R14) Bus attach bit may be set only after the map switch.
`timescale 1ns/100ps
module brs_shadow_map import brs_pkg::*; #(
   parameter logic ATTACH_NEEDS_SHADOW = 1'b1
) (
   // Clock and resets
   input  wire logic                CLK,
   input  wire logic                RST,
   input  wire logic                WDT_RST,
   // Code fetch port
   input  wire logic                CODE_RD,
   input  wire logic [15:0]         CODE_ADDR,
   output      logic [7:0]          CODE_DATA,
   output      logic                CODE_VALID,
   // Data space port
   input  wire logic                XD_RD,
   input  wire logic                XD_WR,
   input  wire logic [15:0]         XD_ADDR,
   input  wire logic [7:0]          XD_WDATA,
   output      logic [7:0]          XD_RDATA,
   output      logic                XD_VALID,
   // Boot ROM port
   output      logic                ROM_RD,
   output      logic [ROM_AW-1:0]   ROM_ADDR,
   input  wire logic [7:0]          ROM_DATA,
   // Mode outputs
   output      logic                SHADOW_ON,
   output      logic                BUS_ATTACH
);

   typedef struct packed {
      logic               shadow;
      logic               attach;
      brs_src_e           src1;
      logic               code1;
      logic [7:0]         reg1;
      brs_src_e           src2;
      logic               code2;
      logic [7:0]         reg2;
      logic [7:0]         ram2;
      logic               rom_rd;
      logic [ROM_AW-1:0]  rom_addr;
      logic [7:0]         code_data;
      logic               code_valid;
      logic [7:0]         xd_rdata;
      logic               xd_valid;
   } brs_state_s;

   localparam brs_state_s STATE_RESET = '{
      shadow: SHADOW_RESET, attach: BUS_ATTACH_RESET,
      src1: SRC_IDLE, code1: 1'b0, reg1: 8'h00,
      src2: SRC_IDLE, code2: 1'b0, reg2: 8'h00, ram2: 8'h00,
      rom_rd: 1'b0, rom_addr: '0,
      code_data: 8'h00, code_valid: 1'b0, xd_rdata: 8'h00, xd_valid: 1'b0};

   brs_state_s          q;
   brs_state_s          d;
   logic                ram_en;
   logic                ram_we;
   logic [RAM_AW-1:0]   ram_addr;
   logic [7:0]          ram_rdata;

   // -----------------------------------------------------------------
   // Decoding
   // -----------------------------------------------------------------
   function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   function automatic brs_src_e code_map(input logic [15:0] a, input logic shadow);
      if (in_range(a, ROM_HIGH_BASE, ROM_HIGH_LAST))
         code_map = SRC_ROM;                                              // R1
      else if (shadow && in_range(a, RAM_BASE, RAM_LAST))
         code_map = SRC_RAM;                                              // R3
      else if (!shadow && in_range(a, ROM_LOW_BASE, ROM_LOW_LAST))
         code_map = SRC_ROM;                                              // R1
      else
         code_map = SRC_ZERO;
   endfunction

   function automatic brs_src_e data_map(input logic [15:0] a, input logic shadow);
      if (!shadow && in_range(a, RAM_BASE, RAM_LAST))
         data_map = SRC_RAM;                                              // R2
      else if (a == ROM_SHADOW_CONFIG_ADDR || a == USB_CONTROL_REG_ADDR)
         data_map = SRC_REG;
      else
         data_map = SRC_ZERO;
   endfunction

   function automatic logic [7:0] rom_shadow_config(input logic shadow);
      rom_shadow_config = {CODE_IS_RAM_VALUE, CODE_SIZE_16K, RSVD_VALUE, shadow}; // R7 R8 R9
   endfunction

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb
   begin
      brs_src_e    src;
      logic [15:0] addr;
      logic [7:0]  sel;
      logic        dwr;
      src  = SRC_IDLE;
      addr = XD_ADDR;
      sel  = 8'h00;
      dwr  = XD_WR && !CODE_RD;
      d    = q;

      if (CODE_RD)
      begin
         src  = code_map(CODE_ADDR, q.shadow);
         addr = CODE_ADDR;
      end
      else if (XD_RD || XD_WR)
      begin
         src = data_map(XD_ADDR, q.shadow);
      end

      d.src1     = (CODE_RD || XD_RD) ? src : SRC_IDLE;
      d.code1    = CODE_RD;
      d.rom_rd   = (d.src1 == SRC_ROM);
      d.rom_addr = d.rom_rd ? addr[ROM_AW-1:0] : q.rom_addr;
      d.reg1     = 8'h00;
      if (addr == ROM_SHADOW_CONFIG_ADDR)
         d.reg1 = rom_shadow_config(q.shadow);                            // R6
      else if (addr == USB_CONTROL_REG_ADDR)
         d.reg1 = {q.attach, 7'h00};

      // Image load into RAM happens only in boot mode
      ram_en    = (src == SRC_RAM);
      ram_we    = dwr && (src == SRC_RAM);                                // R4 R12
      ram_addr  = addr[RAM_AW-1:0];

      if (dwr && XD_ADDR == ROM_SHADOW_CONFIG_ADDR && XD_WDATA[SHADOW_SWITCH_POS])
         d.shadow = 1'b1;                                                 // R5 R13
      if (dwr && XD_ADDR == USB_CONTROL_REG_ADDR)
      begin
         if (!XD_WDATA[BUS_ATTACH_POS])
            d.attach = 1'b0;
         else if (q.shadow || !ATTACH_NEEDS_SHADOW)
            d.attach = 1'b1;                                              // R14
      end

      d.src2  = q.src1;
      d.code2 = q.code1;
      d.reg2  = q.reg1;
      d.ram2  = ram_rdata;

      case (q.src2)
         SRC_ROM:  sel = ROM_DATA;
         SRC_RAM:  sel = q.ram2;
         SRC_REG:  sel = q.reg2;
         default:  sel = 8'h00;
      endcase
      d.code_valid = (q.src2 != SRC_IDLE) && q.code2;
      d.xd_valid   = (q.src2 != SRC_IDLE) && !q.code2;
      d.code_data  = d.code_valid ? sel : q.code_data;
      d.xd_rdata   = d.xd_valid ? sel : q.xd_rdata;

      if (WDT_RST)
      begin
         d.shadow = SHADOW_RESET;                                         // R5 R10
         d.attach = BUS_ATTACH_RESET;
      end
      if (RST)
         d = STATE_RESET;                                                 // R10 R11
   end

   always_ff @(posedge CLK)
   begin
      q <= d;
   end

   // -----------------------------------------------------------------
   // Program RAM
   // -----------------------------------------------------------------
   brs_code_ram #(.AW(RAM_AW), .DW(8)) u_ram (
      .clk   (CLK),
      .en    (ram_en),
      .we    (ram_we),
      .addr  (ram_addr),
      .wdata (XD_WDATA),
      .rdata (ram_rdata)
   );

   assign CODE_DATA  = q.code_data;
   assign CODE_VALID = q.code_valid;
   assign XD_RDATA   = q.xd_rdata;
   assign XD_VALID   = q.xd_valid;
   assign ROM_RD     = q.rom_rd;
   assign ROM_ADDR   = q.rom_addr;
   assign SHADOW_ON  = q.shadow;
   assign BUS_ATTACH = q.attach;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   property p_boot_rom_fetch;
      @(posedge CLK) disable iff (RST)
      CODE_RD && !q.shadow && (CODE_ADDR <= ROM_LOW_LAST || CODE_ADDR >= ROM_HIGH_BASE)
      && CODE_ADDR <= ROM_HIGH_LAST && !WDT_RST
      |=> ROM_RD && ROM_ADDR == $past(CODE_ADDR[ROM_AW-1:0]) ##2 CODE_VALID;
   endproperty
   a_boot_rom_fetch: assert property (p_boot_rom_fetch) else $error("boot rom fetch"); // R1

   property p_boot_ram_write;
      @(posedge CLK) disable iff (RST)
      XD_WR && !CODE_RD && !q.shadow && XD_ADDR <= RAM_LAST |-> ram_en && ram_we;
   endproperty
   a_boot_ram_write: assert property (p_boot_ram_write) else $error("ram write lost"); // R2

   property p_normal_ram_fetch;
      @(posedge CLK) disable iff (RST)
      CODE_RD && q.shadow && CODE_ADDR <= RAM_LAST |=> !ROM_RD ##2 CODE_VALID;
   endproperty
   a_normal_ram_fetch: assert property (p_normal_ram_fetch) else $error("ram fetch"); // R3

   property p_no_code_write;
      @(posedge CLK) disable iff (RST)
      q.shadow |-> !ram_we;
   endproperty
   a_no_code_write: assert property (p_no_code_write) else $error("code ram written"); // R4

   property p_shadow_sticky;
      @(posedge CLK) disable iff (RST)
      q.shadow && !WDT_RST |=> SHADOW_ON;
   endproperty
   a_shadow_sticky: assert property (p_shadow_sticky) else $error("shadow cleared"); // R5

   property p_reserved_zero;
      @(posedge CLK) disable iff (RST)
      XD_RD && !XD_WR && !CODE_RD && XD_ADDR == ROM_SHADOW_CONFIG_ADDR
      |=> ##2 XD_VALID && XD_RDATA[RSVD_MSB:RSVD_LSB] == RSVD_VALUE;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits"); // R6

   property p_fixed_fields;
      @(posedge CLK) disable iff (RST)
      XD_RD && !XD_WR && !CODE_RD && XD_ADDR == ROM_SHADOW_CONFIG_ADDR
      |=> ##2 XD_RDATA[CODE_IS_RAM_POS:CODE_SIZE_LSB] == {CODE_IS_RAM_VALUE, CODE_SIZE_16K}
      && XD_RDATA[SHADOW_SWITCH_POS] == $past(SHADOW_ON, 3);
   endproperty
   a_fixed_fields: assert property (p_fixed_fields) else $error("fixed fields"); // R7 R9

   property p_wdt_clears;
      @(posedge CLK) disable iff (RST)
      WDT_RST |=> !SHADOW_ON && !BUS_ATTACH;
   endproperty
   a_wdt_clears: assert property (p_wdt_clears) else $error("watchdog reset"); // R10

   property p_shadow_set;
      @(posedge CLK) disable iff (RST)
      XD_WR && !CODE_RD && !WDT_RST && XD_ADDR == ROM_SHADOW_CONFIG_ADDR && XD_WDATA[0]
      |=> SHADOW_ON;
   endproperty
   a_shadow_set: assert property (p_shadow_set) else $error("shadow not set"); // R13

   property p_attach_after_switch;
      @(posedge CLK) disable iff (RST)
      $rose(BUS_ATTACH) |-> ($past(SHADOW_ON) || !ATTACH_NEEDS_SHADOW);
   endproperty
   a_attach_after_switch: assert property (p_attach_after_switch) else $error("early attach"); // R14

endmodule

// ### bench/brs_rom_model.sv
// Behavioural boot ROM beside the memory-map switch.
// Assumes the shared clock; contents are a fixed function of the address.
`timescale 1ns/100ps
module brs_rom_model (
   // Clock
   input  wire logic        clk,
   // Read port
   input  wire logic        rd,
   input  wire logic [13:0] addr,
   output      logic [7:0]  data
);
   logic [7:0] junk_q;

   initial junk_q = 8'h00;

   // Synchronous ROM: the byte appears the cycle after rd; outside a read it
   // drives junk_q, which stays 00h because negating zero gives zero
   always @(posedge clk)
   begin
      junk_q <= ~junk_q + 8'h01;
      data   <= rd ? (addr[7:0] ^ {2'h0, addr[13:8]} ^ 8'h5A) : junk_q;
   end
endmodule

// ### bench/brs_shadow_map_tb_top.sv
// Self-checking bench for the boot/normal memory-map switch.
// Assumes brs_pkg and the design are compiled first; the bench acts as MCU.
`timescale 1ns/100ps
module brs_shadow_map_tb_top import brs_pkg::*; ;
   logic              clk;
   logic              rst;
   logic              wdt_rst;
   logic              code_rd;
   logic              xd_rd;
   logic              xd_wr;
   logic [15:0]       code_addr;
   logic [15:0]       xd_addr;
   logic [7:0]        xd_wdata;
   logic [7:0]        rom_data;
   logic [7:0]        code_data;
   logic [7:0]        xd_rdata;
   logic              code_valid;
   logic              xd_valid;
   logic              rom_rd;
   logic              shadow_on;
   logic              bus_attach;
   logic [ROM_AW-1:0] rom_addr;
   logic [7:0]        img [4];
   logic [7:0]        cfg0;
   logic [7:0]        cfg1;
   int                failures;
   int                n_checks;
   int                cycles;

   brs_shadow_map dut (
      .CLK(clk), .RST(rst), .WDT_RST(wdt_rst),
      .CODE_RD(code_rd), .CODE_ADDR(code_addr), .CODE_DATA(code_data),
      .CODE_VALID(code_valid), .XD_RD(xd_rd), .XD_WR(xd_wr), .XD_ADDR(xd_addr),
      .XD_WDATA(xd_wdata), .XD_RDATA(xd_rdata), .XD_VALID(xd_valid),
      .ROM_RD(rom_rd), .ROM_ADDR(rom_addr), .ROM_DATA(rom_data),
      .SHADOW_ON(shadow_on), .BUS_ATTACH(bus_attach)
   );

   brs_rom_model rom (.clk(clk), .rd(rom_rd), .addr(rom_addr), .data(rom_data));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   function automatic logic [7:0] rom_b(input logic [15:0] a);
      return a[7:0] ^ {2'h0, a[13:8]} ^ 8'h5A;
   endfunction

   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
         failures++;
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Read from code space (code=1) or data space; answer exactly two edges on
   task automatic rd(input bit code, input logic [15:0] a, input logic [7:0] exp);
      code_rd   <= code;
      xd_rd     <= !code;
      code_addr <= a;
      xd_addr   <= a;
      @(posedge clk);
      code_rd   <= 1'b0;
      xd_rd     <= 1'b0;
      repeat (READ_LATENCY) @(posedge clk);
      #1;
      if (code)
      begin
         check("code_valid", {7'h0, code_valid}, 8'h01);
         check("code_data", code_data, exp);
      end
      else
      begin
         check("xd_valid", {7'h0, xd_valid}, 8'h01);
         check("xd_rdata", xd_rdata, exp);
      end
      @(posedge clk);
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      xd_wr    <= 1'b1;
      xd_addr  <= a;
      xd_wdata <= d;
      @(posedge clk);
      xd_wr    <= 1'b0;
      @(posedge clk);
   endtask

   task automatic modes(input logic sh, input logic at);
      #1;
      check("shadow_on", {7'h0, shadow_on}, {7'h0, sh});
      check("bus_attach", {7'h0, bus_attach}, {7'h0, at});
      @(posedge clk);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      rst       = 1'b1;
      wdt_rst   = 1'b0;
      code_rd   = 1'b0;
      xd_rd     = 1'b0;
      xd_wr     = 1'b0;
      code_addr = 16'h0000;
      xd_addr   = 16'h0000;
      xd_wdata  = 8'h00;
      failures  = 0;
      n_checks  = 0;
      cfg0      = {CODE_IS_RAM_VALUE, CODE_SIZE_16K, RSVD_VALUE, 1'b0};
      cfg1      = cfg0 | 8'h01;
      img       = '{8'h55, 8'hA3, 8'h0F, 8'hC6};
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      modes(1'b0, 1'b0);
      rd(0, ROM_SHADOW_CONFIG_ADDR, cfg0);
      rd(1, 16'h0000, rom_b(16'h0000));
      rd(1, 16'h8000, rom_b(16'h8000));
      rd(1, 16'h27FF, rom_b(16'h27FF));
      rd(1, 16'hA7FF, rom_b(16'hA7FF));
      rd(1, 16'h2800, 8'h00);
      $display("test boot_map done");
      // Image copied into RAM through data space, then read back
      for (int i = 0; i < 4; i++)
         wr(16'(i), img[i]);
      wr(16'h3FFF, 8'hE7);
      for (int i = 0; i < 4; i++)
         rd(0, 16'(i), img[i]);
      rd(0, 16'h3FFF, 8'hE7);
      wr(ROM_SHADOW_CONFIG_ADDR, 8'h1E);
      rd(0, ROM_SHADOW_CONFIG_ADDR, cfg0);
      wr(USB_CONTROL_REG_ADDR, 8'h80);
      rd(0, USB_CONTROL_REG_ADDR, 8'h00);
      $display("test load done");
      wr(ROM_SHADOW_CONFIG_ADDR, 8'h01);
      modes(1'b1, 1'b0);
      rd(0, ROM_SHADOW_CONFIG_ADDR, cfg1);
      for (int i = 0; i < 4; i++)
         rd(1, 16'(i), img[i]);
      rd(1, 16'h3FFF, 8'hE7);
      rd(1, 16'h8000, rom_b(16'h8000));
      rd(1, 16'h4000, 8'h00);
      wr(16'h0000, 8'h11);
      rd(1, 16'h0000, img[0]);
      rd(0, 16'h0000, 8'h00);
      wr(ROM_SHADOW_CONFIG_ADDR, 8'h00);
      rd(0, ROM_SHADOW_CONFIG_ADDR, cfg1);
      wr(USB_CONTROL_REG_ADDR, 8'h80);
      modes(1'b1, 1'b1);
      rd(0, USB_CONTROL_REG_ADDR, 8'h80);
      $display("test normal done");
      wdt_rst <= 1'b1;
      @(posedge clk);
      wdt_rst <= 1'b0;
      modes(1'b0, 1'b0);
      rd(1, 16'h0000, rom_b(16'h0000));
      rd(0, 16'h0000, img[0]);
      // Back to normal mode and attached, so the reset below has work to do
      wr(ROM_SHADOW_CONFIG_ADDR, 8'h01);
      wr(USB_CONTROL_REG_ADDR, 8'h80);
      modes(1'b1, 1'b1);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      modes(1'b0, 1'b0);
      rd(0, ROM_SHADOW_CONFIG_ADDR, cfg0);
      $display("test resets done");
      tally_and_finish();
   end

   initial
   begin
      cycles = 0;
      forever
      begin
         @(posedge clk);
         cycles++;
         if (cycles == 3000)
         begin
            failures++;
            tally_and_finish();
         end
      end
   end
endmodule
